// [asp_top.sv]
// Start-up delay, power and range configuration registers and the serial
// sample output of an eight-channel converter.
// Assumes register port and samples on i_clk; power pins are asynchronous;
// i_ser_clk is the internal serializer clock, unrelated to i_clk.
`timescale 1ns/1ps
`default_nettype none

`include "asp_map.svh"

// Functional notes
// [RL1] Trim moves range about 0.3 percent per code
// [RL2] Start-up count chosen by clock-frequency setting
// [RL3] Default setting uses longest, highest-frequency count
// [RL4] Frequency setting affects only wake-up delays
// [RL5] Host picks range nearest at or above clock
// [RL6] Power level decodes nominal, four cuts, reserved
// [RL7] Host keeps nominal level, never reserved codes
// [RL8] Buffer drive: off, 6.5, 70, 140 uA
// [RL9] Each channel sends 12/14-bit word serially
// [RL10] Bit clock half serializer rate, frame clock
// [RL11] Codes linear from zero to 8191
// [RL12] Six-bit trim drives monotonic range DAC
// [RL13] 12-bit drops LSB, 14-bit appends zero
// [RL14] Data invalid until start-up count elapses
module asp_top
  import asp_pkg::*;
#(
  parameter int       CHANNELS     = 8,
  parameter int       SAMPLE_W     = 13,
  parameter int       FIFO_DEPTH   = 8,
  parameter bit [5:0] TRIM_ZERO    = 6'h20
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_reg_wr_en,
  input  wire logic                         i_reg_rd_en,
  input  wire logic [7:0]                   i_reg_addr,
  input  wire logic [15:0]                  i_reg_wdata,
  output logic      [15:0]                  o_reg_rdata,
  output logic                              o_reg_rd_valid,
  input  wire logic                         i_power_down,
  input  wire logic                         i_deep_sleep,
  input  wire logic                         i_sample_valid,
  input  wire logic [CHANNELS*SAMPLE_W-1:0] i_sample_data,
  output logic                              o_sample_ready,
  output logic                              o_startup_done,
  output logic      [5:0]                   o_fullscale_trim,
  output logic      [7:0]                   o_fullscale_adj_tenths,
  output logic      [2:0]                   o_core_power_level,
  output logic      [5:0]                   o_power_cut_pct,
  output logic                              o_cm_buffer_enable,
  output logic      [1:0]                   o_cm_buffer_drive,
  input  wire logic                         i_ser_clk,
  output logic      [CHANNELS-1:0]          o_lvds_data,
  output logic                              o_bit_clock,
  output logic                              o_frame_clock_out
);

  generate
    if (CHANNELS < 1 || SAMPLE_W != 13)
    begin : g_bad_param
      $error("asp_top: SAMPLE_W must be 13 and CHANNELS at least 1");
    end
  endgenerate

  function automatic logic [13:0] fmt_word(input logic [12:0] s, input logic w14);
    fmt_word = w14 ? {s, 1'b0} : {2'h0, s[12:1]};
  endfunction

  // Configuration registers
  logic [1:0]  cm_r;
  logic        wlen_r;
  logic [5:0]  trim_r;
  logic [1:0]  clkf_r;
  logic [2:0]  perf_r;
  logic [15:0] rdata_r;
  logic        rd_valid_r;
  logic [5:0]  cut_r;
  logic [7:0]  adj_r;
  logic        cm_en_r;
  logic [1:0]  cm_drv_r;
  logic [7:0]  trim_diff;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cm_r   <= `ASP_CM_RST;
      wlen_r <= `ASP_WLEN_RST;
      trim_r <= `ASP_TRIM_RST;
      clkf_r <= `ASP_CLKF_RST; // RL3
      perf_r <= `ASP_PERF_RST;
    end
    else if (i_reg_wr_en)
    begin
      case (i_reg_addr)
        `ASP_REG_CM_BUF:  cm_r   <= i_reg_wdata[`ASP_CM_LSB +: 2];
        `ASP_REG_WLEN:    wlen_r <= i_reg_wdata[`ASP_WLEN_BIT];
        `ASP_REG_TRIM:    trim_r <= i_reg_wdata[`ASP_TRIM_LSB +: 6]; // RL12
        `ASP_REG_CLKFREQ: clkf_r <= i_reg_wdata[`ASP_CLKF_LSB +: 2];
        `ASP_REG_PERF:    perf_r <= i_reg_wdata[`ASP_PERF_LSB +: 3];
        default:          cm_r   <= cm_r;
      endcase
    end
  end

  // Power-state pins and start-up counter
  logic       pd_s1_r;
  logic       pd_s2_r;
  logic       ds_s1_r;
  logic       ds_s2_r;
  logic       asleep_d_r;
  logic       asleep;
  logic       leave;
  logic [9:0] start_cnt_r;
  logic [9:0] start_load;
  logic       done_r;
  logic       done_nxt;
  logic       fifo_ready;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pd_s1_r <= 1'b0;
      pd_s2_r <= 1'b0;
      ds_s1_r <= 1'b0;
      ds_s2_r <= 1'b0;
    end
    else
    begin
      pd_s1_r <= i_power_down;
      pd_s2_r <= pd_s1_r;
      ds_s1_r <= i_deep_sleep;
      ds_s2_r <= ds_s1_r;
    end
  end

  assign asleep = pd_s2_r | ds_s2_r;
  assign leave  = asleep_d_r & ~asleep; // RL4

  always_comb
  begin
    case (asp_clk_range_t'(clkf_r))
      ASP_CLK_50_80: start_load = `ASP_START_CNT_00; // RL2
      ASP_CLK_32_50: start_load = `ASP_START_CNT_01; // RL2
      ASP_CLK_20_32: start_load = `ASP_START_CNT_10; // RL2
      ASP_CLK_15_20: start_load = `ASP_START_CNT_11; // RL2
      default:       start_load = `ASP_START_CNT_00;
    endcase
  end

  always_comb
  begin
    if (asleep || leave)
    begin
      done_nxt = 1'b0;
    end
    else if (start_cnt_r == 10'h001)
    begin
      done_nxt = 1'b1; // RL14
    end
    else
    begin
      done_nxt = done_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      asleep_d_r  <= 1'b0;
      start_cnt_r <= `ASP_START_CNT_00; // RL3
      done_r      <= 1'b0;
    end
    else
    begin
      asleep_d_r <= asleep;
      done_r     <= done_nxt;
      if (leave)
      begin
        start_cnt_r <= start_load; // RL2
      end
      else if (!asleep && start_cnt_r != 10'h000)
      begin
        start_cnt_r <= start_cnt_r - 10'h001; // RL14
      end
    end
  end

  // Decoded analog controls
  assign trim_diff = {2'h0, TRIM_ZERO} - {2'h0, trim_r};

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cut_r    <= `ASP_CUT_NONE;
      adj_r    <= 8'h00;
      cm_en_r  <= 1'b1;
      cm_drv_r <= `ASP_CM_RST;
    end
    else
    begin
      case (perf_r)
        3'h4:    cut_r <= `ASP_CUT_100; // RL6
        3'h5:    cut_r <= `ASP_CUT_101; // RL6
        3'h6:    cut_r <= `ASP_CUT_110; // RL6
        3'h7:    cut_r <= `ASP_CUT_111; // RL6
        default: cut_r <= `ASP_CUT_NONE; // RL7
      endcase
      adj_r    <= trim_diff * `ASP_TRIM_STEP; // RL1
      cm_en_r  <= (cm_r != 2'h0); // RL8
      cm_drv_r <= cm_r; // RL8
    end
  end

  // Register read port
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_r    <= 16'h0000;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= i_reg_rd_en;
      if (i_reg_rd_en)
      begin
        rdata_r <= 16'h0000;
        case (i_reg_addr)
          `ASP_REG_CM_BUF:  rdata_r[`ASP_CM_LSB +: 2]   <= cm_r;
          `ASP_REG_WLEN:    rdata_r[`ASP_WLEN_BIT]      <= wlen_r;
          `ASP_REG_TRIM:    rdata_r[`ASP_TRIM_LSB +: 6] <= trim_r;
          `ASP_REG_CLKFREQ: rdata_r[`ASP_CLKF_LSB +: 2] <= clkf_r;
          `ASP_REG_PERF:    rdata_r[`ASP_PERF_LSB +: 3] <= perf_r;
          `ASP_REG_STATUS:
          begin
            rdata_r[`ASP_STAT_DONE]   <= done_r;
            rdata_r[`ASP_STAT_ASLEEP] <= asleep;
            rdata_r[`ASP_STAT_READY]  <= fifo_ready;
          end
          default:          rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  // Sample FIFO towards the serializer domain
  logic                         link_rst1_r;
  logic                         link_rst_n_r;
  logic                         rd_valid;
  logic [CHANNELS*SAMPLE_W-1:0] rd_data;
  logic                         rd_ready;

  always_ff @(posedge i_ser_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      link_rst1_r  <= 1'b0;
      link_rst_n_r <= 1'b0;
    end
    else
    begin
      link_rst1_r  <= 1'b1;
      link_rst_n_r <= link_rst1_r;
    end
  end

  // Samples offered before start-up completes are taken and discarded
  asp_fifo #(
    .WIDTH (CHANNELS*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_wr_clk   (i_clk),
    .i_wr_rst_n (i_rst_n),
    .i_wr_valid (i_sample_valid & done_r), // RL14
    .i_wr_data  (i_sample_data),
    .o_wr_ready (fifo_ready),
    .i_rd_clk   (i_ser_clk),
    .i_rd_rst_n (link_rst_n_r),
    .o_rd_valid (rd_valid),
    .o_rd_data  (rd_data),
    .i_rd_ready (rd_ready)
  );

  // Serializer domain
  logic                     done_l1_r;
  logic                     done_l2_r;
  logic                     wlen_l1_r;
  logic                     wlen_l2_r;
  asp_ser_state_t           state_r;
  logic [3:0]               bit_cnt_r;
  logic [3:0]               len_r;
  logic                     frame_r;
  logic                     bitclk_r;
  logic [CHANNELS-1:0]      lvds_r;
  logic                     word_end;
  logic                     load;
  logic [3:0]               len_new;

  always_ff @(posedge i_ser_clk or negedge link_rst_n_r)
  begin
    if (!link_rst_n_r)
    begin
      done_l1_r <= 1'b0;
      done_l2_r <= 1'b0;
      wlen_l1_r <= 1'b0;
      wlen_l2_r <= 1'b0;
    end
    else
    begin
      done_l1_r <= done_r;
      done_l2_r <= done_l1_r;
      wlen_l1_r <= wlen_r;
      wlen_l2_r <= wlen_l1_r;
    end
  end

  assign word_end = (state_r == ASP_SER_IDLE) || (bit_cnt_r == len_r);
  assign rd_ready = word_end & done_l2_r;
  assign load     = rd_ready & rd_valid;
  assign len_new  = wlen_l2_r ? `ASP_WORD14_LEN : `ASP_WORD12_LEN; // RL13

  always_ff @(posedge i_ser_clk or negedge link_rst_n_r)
  begin
    if (!link_rst_n_r)
    begin
      state_r   <= ASP_SER_IDLE;
      bit_cnt_r <= 4'h0;
      len_r     <= `ASP_WORD12_LEN;
      frame_r   <= 1'b0;
    end
    else if (load)
    begin
      state_r   <= ASP_SER_SEND;
      bit_cnt_r <= 4'h1;
      len_r     <= len_new;
      frame_r   <= 1'b1; // RL10
    end
    else if (word_end)
    begin
      state_r   <= ASP_SER_IDLE;
      bit_cnt_r <= 4'h0;
      frame_r   <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      frame_r   <= (bit_cnt_r < (len_r >> 1)); // RL10
    end
  end

  // Free-running bit clock at half the serializer rate
  always_ff @(posedge i_ser_clk or negedge link_rst_n_r)
  begin
    if (!link_rst_n_r)
    begin
      bitclk_r <= 1'b0;
    end
    else
    begin
      bitclk_r <= ~bitclk_r; // RL10
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_lane
      logic [13:0] word;
      logic [13:0] shift_r;

      // Offset-binary code passes into the word without recoding; 12-bit drops its LSB, 14-bit appends a zero
      assign word = fmt_word(rd_data[ch*SAMPLE_W +: SAMPLE_W], wlen_l2_r); // RL11

      always_ff @(posedge i_ser_clk or negedge link_rst_n_r)
      begin
        if (!link_rst_n_r)
        begin
          shift_r   <= 14'h0000;
          lvds_r[ch] <= 1'b0;
        end
        else if (load)
        begin
          shift_r    <= word >> 1; // RL9
          lvds_r[ch] <= word[0]; // RL9
        end
        else if (word_end)
        begin
          lvds_r[ch] <= 1'b0;
        end
        else
        begin
          shift_r    <= shift_r >> 1; // RL9
          lvds_r[ch] <= shift_r[0];
        end
      end
    end
  endgenerate

  assign o_reg_rdata            = rdata_r;
  assign o_reg_rd_valid         = rd_valid_r;
  assign o_sample_ready         = fifo_ready;
  assign o_startup_done         = done_r;
  assign o_fullscale_trim       = trim_r;
  assign o_fullscale_adj_tenths = adj_r;
  assign o_core_power_level     = perf_r;
  assign o_power_cut_pct        = cut_r;
  assign o_cm_buffer_enable     = cm_en_r;
  assign o_cm_buffer_drive      = cm_drv_r;
  assign o_lvds_data            = lvds_r;
  assign o_bit_clock            = bitclk_r;
  assign o_frame_clock_out      = frame_r;

endmodule

`default_nettype wire

// [asp_map.svh]
// Register map, field positions, reset values and start-up counts
// of the converter start-up and power configuration block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// Register offsets on the control register port
`define ASP_REG_CM_BUF    8'h50
`define ASP_REG_WLEN      8'h53
`define ASP_REG_TRIM      8'h55
`define ASP_REG_CLKFREQ   8'h5A
`define ASP_REG_STATUS    8'h5B
`define ASP_REG_PERF      8'hF0

// Field positions
`define ASP_CM_LSB        4
`define ASP_WLEN_BIT      1
`define ASP_TRIM_LSB      0
`define ASP_CLKF_LSB      0
`define ASP_PERF_LSB      0
`define ASP_STAT_DONE     0
`define ASP_STAT_ASLEEP   1
`define ASP_STAT_READY    2

// Reset values
`define ASP_CM_RST        2'h1
`define ASP_WLEN_RST      1'h0
`define ASP_TRIM_RST      6'h20
`define ASP_CLKF_RST      2'h0
`define ASP_PERF_RST      3'h0

// Start-up delay in input clock cycles per clock-frequency range
`define ASP_START_CNT_00  10'h3E0
`define ASP_START_CNT_01  10'h280
`define ASP_START_CNT_10  10'h1A4
`define ASP_START_CNT_11  10'h104

// Analog power cut in percent per core power level
`define ASP_CUT_100       6'h28
`define ASP_CUT_101       6'h1E
`define ASP_CUT_110       6'h14
`define ASP_CUT_111       6'h0A
`define ASP_CUT_NONE      6'h00

// Full-scale trim step in tenths of a percent
`define ASP_TRIM_STEP     8'h03

// Serial word lengths
`define ASP_WORD12_LEN    4'hC
`define ASP_WORD14_LEN    4'hE

`endif

// [asp_pkg.sv]
// Types shared by the start-up and power configuration block.
// Assumes asp_map.svh is on the include path.
`include "asp_map.svh"

package asp_pkg;

  typedef enum logic [1:0]
  {
    ASP_CLK_50_80,
    ASP_CLK_32_50,
    ASP_CLK_20_32,
    ASP_CLK_15_20
  } asp_clk_range_t;

  typedef enum logic
  {
    ASP_SER_IDLE,
    ASP_SER_SEND
  } asp_ser_state_t;

endpackage

// [asp_fifo.sv]
// Dual-clock sample FIFO with gray-coded pointers and a registered read port.
// Assumes independent write and read clocks, each with its own active-low reset.
`timescale 1ns/1ps
`default_nettype none

module asp_fifo #(
  parameter int WIDTH = 104,
  parameter int DEPTH = 8
) (
  input  wire logic             i_wr_clk,
  input  wire logic             i_wr_rst_n,
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  input  wire logic             i_rd_clk,
  input  wire logic             i_rd_rst_n,
  output logic                  o_rd_valid,
  output logic [WIDTH-1:0]      o_rd_data,
  input  wire logic             i_rd_ready
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_param
      $error("asp_fifo: DEPTH must be a power of two of at least 4");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_r;
  logic [AW:0]      wgray_r;
  logic [AW:0]      rbin_r;
  logic [AW:0]      rgray_r;
  logic [AW:0]      rq1_r;
  logic [AW:0]      rq2_r;
  logic [AW:0]      wq1_r;
  logic [AW:0]      wq2_r;
  logic             ready_r;
  logic             valid_r;
  logic [WIDTH-1:0] data_r;
  logic             wr_fire;
  logic [AW:0]      wbin_nxt;
  logic [AW:0]      wgray_nxt;
  logic             rd_load;
  logic [AW:0]      rbin_nxt;

  assign wr_fire   = i_wr_valid & ready_r;
  assign wbin_nxt  = wbin_r + {{AW{1'b0}}, wr_fire};
  assign wgray_nxt = (wbin_nxt >> 1) ^ wbin_nxt;

  always_ff @(posedge i_wr_clk or negedge i_wr_rst_n)
  begin
    if (!i_wr_rst_n)
    begin
      rq1_r <= '0;
      rq2_r <= '0;
    end
    else
    begin
      rq1_r <= rgray_r;
      rq2_r <= rq1_r;
    end
  end

  always_ff @(posedge i_wr_clk or negedge i_wr_rst_n)
  begin
    if (!i_wr_rst_n)
    begin
      wbin_r  <= '0;
      wgray_r <= '0;
      ready_r <= 1'b1;
    end
    else
    begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wgray_nxt;
      ready_r <= (wgray_nxt != {~rq2_r[AW:AW-1], rq2_r[AW-2:0]});
    end
  end

  always_ff @(posedge i_wr_clk)
  begin
    if (wr_fire)
    begin
      mem[wbin_r[AW-1:0]] <= i_wr_data;
    end
  end

  // Read side keeps one word in the output register ahead of demand
  assign rd_load  = (rgray_r != wq2_r) & (~valid_r | i_rd_ready);
  assign rbin_nxt = rbin_r + {{AW{1'b0}}, rd_load};

  always_ff @(posedge i_rd_clk or negedge i_rd_rst_n)
  begin
    if (!i_rd_rst_n)
    begin
      wq1_r <= '0;
      wq2_r <= '0;
    end
    else
    begin
      wq1_r <= wgray_r;
      wq2_r <= wq1_r;
    end
  end

  always_ff @(posedge i_rd_clk or negedge i_rd_rst_n)
  begin
    if (!i_rd_rst_n)
    begin
      rbin_r  <= '0;
      rgray_r <= '0;
      valid_r <= 1'b0;
      data_r  <= '0;
    end
    else
    begin
      rbin_r  <= rbin_nxt;
      rgray_r <= (rbin_nxt >> 1) ^ rbin_nxt;
      if (rd_load)
      begin
        data_r  <= mem[rbin_r[AW-1:0]];
        valid_r <= 1'b1;
      end
      else if (i_rd_ready)
      begin
        valid_r <= 1'b0;
      end
    end
  end

  assign o_wr_ready = ready_r;
  assign o_rd_valid = valid_r;
  assign o_rd_data  = data_r;

endmodule

`default_nettype wire

// [asp_top_monitor.sv]
// Checker of the configuration outputs, start-up timing and serial framing.
// Assumes binding into asp_top; link outputs are sampled on i_ser_clk.
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.svh"
module asp_top_monitor
  import asp_pkg::*;
#(
  parameter bit [5:0] TRIM_ZERO = 6'h20
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_reg_wr_en,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_power_down,
  input wire logic        i_deep_sleep,
  input wire logic        o_startup_done,
  input wire logic [5:0]  o_fullscale_trim,
  input wire logic [7:0]  o_fullscale_adj_tenths,
  input wire logic [2:0]  o_core_power_level,
  input wire logic [5:0]  o_power_cut_pct,
  input wire logic [1:0]  o_cm_buffer_drive,
  input wire logic        i_ser_clk,
  input wire logic        o_bit_clock,
  input wire logic        o_frame_clock_out
);
  logic [1:0]  clkf_r;
  logic [10:0] wait_r;
  logic [10:0] need;
  logic        asleep;

  assign asleep = i_power_down | i_deep_sleep;
  always_comb
    case (clkf_r)
      2'h0:    need = 11'h3E0;
      2'h1:    need = 11'h280;
      2'h2:    need = 11'h1A4;
      default: need = 11'h104;
    endcase
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      clkf_r <= 2'h0;
    else if (i_reg_wr_en && i_reg_addr == `ASP_REG_CLKFREQ)
      clkf_r <= i_reg_wdata[1:0];
  // Cycles spent awake but not yet started
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      wait_r <= 11'h0;
    else if (asleep || o_startup_done)
      wait_r <= 11'h0;
    else
      wait_r <= wait_r + 11'h1;

  function automatic logic [5:0] cut_of(logic [2:0] l);
    case (l)
      3'h4:    return 6'h28;
      3'h5:    return 6'h1E;
      3'h6:    return 6'h14;
      3'h7:    return 6'h0A;
      default: return 6'h00;
    endcase
  endfunction

  sequence frame_hi6;
    o_frame_clock_out [*6];
  endsequence
  sequence wr_to(logic [7:0] a);
    i_reg_wr_en && i_reg_addr == a;
  endsequence

  trim_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_to(`ASP_REG_TRIM) |=> o_fullscale_trim == $past(i_reg_wdata[5:0])) else $error("trim not written");
  trim_adj_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_fullscale_adj_tenths == 8'(({2'h0, TRIM_ZERO} - {2'h0, $past(o_fullscale_trim)}) * 8'h03))
    else $error("trim adjust wrong");
  level_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_to(`ASP_REG_PERF) |=> o_core_power_level == $past(i_reg_wdata[2:0])) else $error("level not written");
  cut_dec_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_power_cut_pct == cut_of($past(o_core_power_level))) else $error("power cut wrong");
  cm_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_to(`ASP_REG_CM_BUF) |-> ##2 o_cm_buffer_drive == $past(i_reg_wdata[5:4], 2)) else $error("drive wrong");
  sleep_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(asleep) |-> ##[1:5] !o_startup_done) else $error("done held in sleep");
  start_cnt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_startup_done) |-> wait_r >= need - 11'h2 && wait_r <= need + 11'h6) else $error("start-up count wrong");
  clkf_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_to(`ASP_REG_CLKFREQ) and o_startup_done && !asleep |=> o_startup_done [*2]) else $error("done disturbed");
  frame_len_a: assert property (@(posedge i_ser_clk) disable iff (!i_rst_n)
    $rose(o_frame_clock_out) |-> frame_hi6 ##1 (!o_frame_clock_out or (o_frame_clock_out ##1 !o_frame_clock_out)))
    else $error("frame length wrong");
  bit_clk_a: assert property (@(posedge i_ser_clk) disable iff (!i_rst_n)
    $rose(o_bit_clock) |=> $fell(o_bit_clock) ##1 $rose(o_bit_clock)) else $error("bit clock stopped");
endmodule
`default_nettype wire

// [asp_rx_model.sv]
// Receiver model: captures one word per channel, LSB first, from the frame start.
// Assumes data and frame change just after rising edges of the serializer clock.
`timescale 1ns/1ps
`default_nettype none
module asp_rx_model #(
  parameter int CHANNELS = 8
) (
  input wire logic                i_ser_clk,
  input wire logic                i_len14,
  input wire logic [CHANNELS-1:0] i_lvds_data,
  input wire logic                i_frame
);
  logic [CHANNELS*14-1:0] words[$];
  logic [CHANNELS*14-1:0] cur = '0;
  logic                   prev = 1'b0;
  int                     bitn = -1;
  int                     len;

  always @(posedge i_ser_clk)
  begin
    len = i_len14 ? 14 : 12;
    if (i_frame && !prev)
      bitn = 0;
    if (bitn >= 0)
    begin
      for (int c = 0; c < CHANNELS; c++)
        cur[c*14+bitn] = i_lvds_data[c];
      bitn++;
      if (bitn == len)
      begin
        words.push_back(cur);
        cur = '0;
        bitn = -1;
      end
    end
    prev = i_frame;
  end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench of the start-up, power configuration and serial output block.
// Assumes the design, asp_top_monitor and asp_rx_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.svh"
module tb;
  import asp_pkg::*;
  logic         i_clk = 1'b0;
  logic         i_ser_clk = 1'b0;
  logic         i_rst_n = 1'b0;
  logic         i_reg_wr_en = 1'b0;
  logic         i_reg_rd_en = 1'b0;
  logic [7:0]   i_reg_addr = 8'h00;
  logic [15:0]  i_reg_wdata = 16'h0000;
  logic         i_power_down = 1'b0;
  logic         i_deep_sleep = 1'b0;
  logic         i_sample_valid = 1'b0;
  logic [103:0] i_sample_data = 104'h0;
  logic         len14 = 1'b0;
  logic [15:0]  o_reg_rdata;
  logic [7:0]   o_fullscale_adj_tenths, o_lvds_data;
  logic [5:0]   o_fullscale_trim, o_power_cut_pct;
  logic [2:0]   o_core_power_level;
  logic [1:0]   o_cm_buffer_drive;
  logic         o_reg_rd_valid, o_sample_ready, o_startup_done, o_cm_buffer_enable, o_bit_clock, o_frame_clock_out;
  logic [111:0] exp_q[$];
  logic [5:0]   t;
  logic [2:0]   l;
  int           num_errors = 0;
  int           num_checks = 0;
  int           n;

  asp_top dut_u (
    .i_clk, .i_rst_n, .i_reg_wr_en, .i_reg_rd_en, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_reg_rd_valid, .i_power_down, .i_deep_sleep, .i_sample_valid, .i_sample_data,
    .o_sample_ready, .o_startup_done, .o_fullscale_trim, .o_fullscale_adj_tenths,
    .o_core_power_level, .o_power_cut_pct, .o_cm_buffer_enable, .o_cm_buffer_drive,
    .i_ser_clk, .o_lvds_data, .o_bit_clock, .o_frame_clock_out
  );
  asp_rx_model rx_u (.i_ser_clk, .i_len14(len14), .i_lvds_data(o_lvds_data), .i_frame(o_frame_clock_out));

  initial forever #20 i_clk = ~i_clk;
  initial
  begin
    #7;
    forever #40 i_ser_clk = ~i_ser_clk;
  end

  task automatic chk(string name, logic [111:0] exp, logic [111:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(negedge i_clk);
    i_reg_wr_en = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr_en = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp, string name);
    @(negedge i_clk);
    i_reg_rd_en = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk);
    chk("read valid", 1'b1, o_reg_rd_valid);
    chk(name, exp, o_reg_rdata);
    i_reg_rd_en = 1'b0;
  endtask
  function automatic logic [111:0] word(logic [103:0] d, bit w14);
    logic [111:0] w = 112'h0;
    for (int c = 0; c < 8; c++)
      w[c*14 +: 14] = w14 ? {d[c*13 +: 13], 1'b0} : {2'h0, d[c*13+1 +: 12]};
    return w;
  endfunction
  // Sleep by one pin, offer a sample that must be dropped, then time the wake-up
  task automatic wake(int r, bit deep);
    int cnt;
    int need;
    need = r == 0 ? 992 : r == 1 ? 640 : r == 2 ? 420 : 260;
    cnt = 0;
    wr(`ASP_REG_CLKFREQ, 16'(r));
    @(negedge i_clk);
    i_deep_sleep = deep;
    i_power_down = !deep;
    repeat (8) @(negedge i_clk);
    chk("done asleep", 1'b0, o_startup_done);
    rd(`ASP_REG_STATUS, 16'h0006, "status asleep");
    i_sample_data = 104'({$urandom, $urandom, $urandom, $urandom});
    i_sample_valid = 1'b1;
    @(negedge i_clk);
    i_sample_valid = 1'b0;
    i_deep_sleep = 1'b0;
    i_power_down = 1'b0;
    while (o_startup_done !== 1'b1 && cnt < 1100)
    begin
      @(negedge i_clk);
      cnt++;
    end
    chk("startup time", 1'b1, cnt >= need && cnt <= need + 6);
  endtask
  task automatic stream(bit w14);
    int full;
    full = 0;
    len14 = w14;
    wr(`ASP_REG_WLEN, {14'h0, w14, 1'b0});
    repeat (8) @(negedge i_clk);
    repeat (12)
    begin
      @(negedge i_clk);
      i_sample_data = 104'({$urandom, $urandom, $urandom, $urandom});
      i_sample_valid = 1'b1;
      while (o_sample_ready !== 1'b1)
      begin
        full++;
        @(negedge i_clk);
      end
      exp_q.push_back(word(i_sample_data, w14));
    end
    @(negedge i_clk);
    i_sample_valid = 1'b0;
    chk("buffer refused", 1'b1, full > 0);
    n = 0;
    while (rx_u.words.size() < exp_q.size() && n < 3000)
    begin
      @(negedge i_clk);
      n++;
    end
    repeat (40) @(negedge i_clk);
    chk("word count", exp_q.size(), rx_u.words.size());
    while (exp_q.size() > 0 && rx_u.words.size() > 0)
      chk("serial word", exp_q.pop_front(), rx_u.words.pop_front());
    exp_q.delete();
    rx_u.words.delete();
  endtask

  initial
  begin
    void'($urandom(32'hB186));
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    n = 0;
    while (o_startup_done !== 1'b1 && n < 1100)
    begin
      @(negedge i_clk);
      n++;
    end
    chk("default startup", 1'b1, n >= 990 && n <= 998);
    rd(`ASP_REG_CM_BUF, 16'h0010, "cm reset");
    rd(`ASP_REG_PERF, 16'h0000, "level reset");
    rd(`ASP_REG_TRIM, 16'h0020, "trim reset");
    rd(`ASP_REG_CLKFREQ, 16'h0000, "range reset");
    rd(`ASP_REG_STATUS, 16'h0005, "status");
    rd(8'h7E, 16'h0000, "unmapped");
    for (int r = 3; r >= 0; r--)
      wake(r, r % 2);
    for (int i = 0; i < 6; i++)
    begin
      t = i == 0 ? 6'h00 : i == 1 ? 6'h3F : 6'($urandom);
      wr(`ASP_REG_TRIM, {10'h0, t});
      chk("trim", t, o_fullscale_trim);
      @(negedge i_clk);
      chk("trim adjust", 8'((32 - t) * 3), o_fullscale_adj_tenths);
    end
    for (int i = 0; i < 5; i++)
    begin
      l = i == 0 ? 3'h0 : 3'(i + 3);
      wr(`ASP_REG_PERF, {13'h0, l});
      repeat (2) @(negedge i_clk);
      chk("level", l, o_core_power_level);
      chk("power cut", i == 0 ? 0 : 50 - 10 * i, o_power_cut_pct);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(`ASP_REG_CM_BUF, 16'(i << 4));
      repeat (2) @(negedge i_clk);
      chk("cm drive", i, o_cm_buffer_drive);
      chk("cm enable", i != 0, o_cm_buffer_enable);
    end
    stream(1'b0);
    stream(1'b1);
    give_verdict();
  end

  initial
  begin
    #(20000 * 40);
    num_errors++;
    give_verdict();
  end
endmodule

bind asp_top asp_top_monitor #(.TRIM_ZERO(TRIM_ZERO)) mon_u (
  .i_clk, .i_rst_n, .i_reg_wr_en, .i_reg_addr, .i_reg_wdata, .i_power_down, .i_deep_sleep,
  .o_startup_done, .o_fullscale_trim, .o_fullscale_adj_tenths, .o_core_power_level,
  .o_power_cut_pct, .o_cm_buffer_drive, .i_ser_clk, .o_bit_clock, .o_frame_clock_out
);
`default_nettype wire
